// ---- rtl/asc_pkg.sv ----
// constants, register map and field layout of the converter sequencer control
// Overview of operation
// - six channels, one converter, 12-bit result
// - high result register holds bits 11..4
// - low result register bits 7..4 hold 3..0
// - control: start b7, busy b6, pins, channel
// - channel codes 0..5 select inputs, others none
// - pin code N enables pins 0..N-1, 6/7 all
// - pin code zero: digital pins, converter off
// - start rise then fall launches conversion
// - start held high: converter reset, busy one
// - busy reads one until conversion completes or power drops while converting
// - completion sets request flag, gated interrupt
// - power on needs pins nonzero and not off
// - clock divide 2, 8, 32 by select code
// - conversion lasts sixteen conversion clock periods
// - analog pins override direction, drop pull-up
package asc_pkg;
    localparam int ASC_DATA_W = 12;
    localparam int ASC_CHANNELS = 6;
    localparam logic [ASC_CHANNELS-1:0] ASC_NO_PINS = 6'h00;
    localparam logic [2:0] ASC_CH_LAST = 3'h5;
    // register byte addresses on the bus
    localparam logic [3:0] ASC_ADDR_RES_LOW = 4'h0;
    localparam logic [3:0] ASC_ADDR_RES_HIGH = 4'h4;
    localparam logic [3:0] ASC_ADDR_CONTROL = 4'h8;
    localparam logic [3:0] ASC_ADDR_CLKSRC = 4'hC;
    localparam logic [3:0] ASC_ADDR_IRQ = 4'hC;
    // control register fields
    localparam int ASC_BIT_START = 7;
    localparam int ASC_BIT_BUSY = 6;
    localparam int ASC_PIN_HI = 5;
    localparam int ASC_PIN_LO = 3;
    localparam int ASC_CH_HI = 2;
    localparam int ASC_CH_LO = 0;
    // clock source register fields
    localparam int ASC_BIT_POWER_OFF = 7;
    localparam int ASC_BIT_DIV_HI = 1;
    localparam int ASC_BIT_DIV_LO = 0;
    // extra interrupt bits in clock source word
    localparam int ASC_BIT_IRQ_FLAG = 8;
    localparam int ASC_BIT_IRQ_EN = 9;
    localparam int ASC_BIT_GLOBAL_EN = 10;
    localparam logic [7:0] ASC_CTRL_RESET = 8'h00;
    localparam logic [7:0] ASC_CLKSRC_RESET = 8'h80;
    localparam logic [1:0] ASC_DIV2 = 2'h0;
    localparam logic [1:0] ASC_DIV8 = 2'h1;
    localparam logic [1:0] ASC_DIV32 = 2'h2;
    localparam logic [4:0] ASC_HALF2 = 5'h00;
    localparam logic [4:0] ASC_HALF8 = 5'h03;
    localparam logic [4:0] ASC_HALF32 = 5'h0F;
    localparam logic [4:0] ASC_PERIODS = 5'h10;
    localparam logic [5:0] ASC_SYSCLK_PER_CONV_MAX = 6'h20;
    localparam int ASC_CLK_PERIOD_NS = 40;
    typedef enum logic [1:0] {
        ASC_IDLE = 2'b00,
        ASC_HELD = 2'b01,
        ASC_CONV = 2'b10
    } asc_state_type;
endpackage

// ---- rtl/asc_control.sv ----
// register slave, clock divider and conversion sequencer for the six-channel converter
module asc_control import asc_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [ASC_DATA_W-1:0] convData,
    output logic [2:0] channelSelect,
    output logic channelValid,
    output logic [ASC_CHANNELS-1:0] analogPinEnable,
    output logic convPowerOn,
    output logic convReset,
    output logic convClockEn,
    output logic convInterrupt
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] clkSrc_q;
    logic busy_q;
    logic irqFlag_q;
    logic irqEn_q;
    logic globalEn_q;
    logic [ASC_DATA_W-1:0] result_q;
    logic [31:0] rdData_q;
    logic ack_q;
    asc_state_type state_q;
    logic [4:0] divCnt_q;
    logic convTick_q;
    logic [4:0] periodCnt_q;
    logic [ASC_CHANNELS-1:0] pinEn_q;
    logic powerOn_q;
    logic held_q;
    logic irqOut_q;
    logic [2:0] chSel_q;
    logic chValid_q;
    logic divPhase_q;
    logic [9:0] convLen_q;
    logic divTouched_q;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire logic busReq = wb_cyc_i && wb_stb_i && !ack_q;
    wire logic wrStb = busReq && wb_we_i && wb_sel_i[0];
    wire logic wrCtrl = wrStb && (wb_adr_i == ASC_ADDR_CONTROL);
    wire logic wrClk = wrStb && (wb_adr_i == ASC_ADDR_CLKSRC);
    wire logic wrIrqLane = wrClk && wb_sel_i[1];
    wire logic startNew = wb_dat_i[ASC_BIT_START];
    wire logic startOld = ctrl_q[ASC_BIT_START];
    wire logic startRise = wrCtrl && startNew && !startOld;
    wire logic startFall = wrCtrl && !startNew && startOld;

    // pin field decode: N enables pins 0..N-1, codes 6 and 7 all
    function automatic logic [ASC_CHANNELS-1:0] pinMask(input logic [2:0] code);
        logic [ASC_CHANNELS-1:0] m;
        m = ASC_NO_PINS;
        for (int i = 0; i < ASC_CHANNELS; i++) begin
            if (3'(i) < code) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    wire logic [2:0] pinCode = ctrl_q[ASC_PIN_HI:ASC_PIN_LO];
    wire logic [ASC_CHANNELS-1:0] pinDec = pinMask(pinCode);
    // zero code leaves all pins digital and drops power
    wire logic pinsUsed = (pinCode != 3'h0);
    wire logic powerDec = pinsUsed && !clkSrc_q[ASC_BIT_POWER_OFF];
    wire logic [2:0] chCode = ctrl_q[ASC_CH_HI:ASC_CH_LO];
    wire logic chOk = (chCode <= ASC_CH_LAST);

    wire logic [1:0] divSel = clkSrc_q[ASC_BIT_DIV_HI:ASC_BIT_DIV_LO];
    // code 3 is undefined; it reuses the slowest rate so nothing stalls
    wire logic [4:0] halfLimit = (divSel == ASC_DIV2) ? ASC_HALF2 :
                                 (divSel == ASC_DIV8) ? ASC_HALF8 : ASC_HALF32;
    wire logic divWrap = (divCnt_q >= halfLimit);

    wire logic [7:0] ctrlRead = {ctrl_q[ASC_BIT_START], busy_q, ctrl_q[5:0]};
    wire logic [31:0] clkRead = {21'h000000, globalEn_q, irqEn_q, irqFlag_q, clkSrc_q};
    wire logic [31:0] rdMux =
        (wb_adr_i == ASC_ADDR_RES_LOW) ? {24'h000000, result_q[3:0], 4'h0} :
        (wb_adr_i == ASC_ADDR_RES_HIGH) ? {24'h000000, result_q[11:4]} :
        (wb_adr_i == ASC_ADDR_CONTROL) ? {24'h000000, ctrlRead} :
        (wb_adr_i == ASC_ADDR_CLKSRC) ? clkRead : 32'h00000000;

    wire logic convDone = (state_q == ASC_CONV) && convTick_q && (periodCnt_q == ASC_PERIODS - 5'h01);

    // ------------------------------------------------------------
    // bus slave: registered ack one cycle after the request, unmapped reads give zero
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdData_q <= 32'h00000000;
        end else begin
            ack_q <= busReq;
            rdData_q <= busReq ? rdMux : 32'h00000000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= ASC_CTRL_RESET;
            clkSrc_q <= ASC_CLKSRC_RESET;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= {wb_dat_i[ASC_BIT_START], 1'b0, wb_dat_i[5:0]};
            end
            if (wrClk) begin
                clkSrc_q <= wb_dat_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqEn_q <= 1'b0;
            globalEn_q <= 1'b0;
        end else if (wrIrqLane) begin
            irqEn_q <= wb_dat_i[ASC_BIT_IRQ_EN];
            globalEn_q <= wb_dat_i[ASC_BIT_GLOBAL_EN];
        end
    end

    // ------------------------------------------------------------
    // conversion clock divider
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst || state_q != ASC_CONV) begin
            divCnt_q <= 5'h00;
            divPhase_q <= 1'b0;
            convTick_q <= 1'b0;
        end else begin
            divCnt_q <= divWrap ? 5'h00 : divCnt_q + 5'h01;
            // a wrap is half a period, so only every second wrap ticks
            divPhase_q <= divPhase_q ^ divWrap;
            convTick_q <= divWrap && divPhase_q;
        end
    end

    // ------------------------------------------------------------
    // helper count of clocks spent converting, read by the checks only
    // ------------------------------------------------------------
    // a divider rewrite mid-conversion leaves the length undefined
    wire logic [9:0] convLenExp = 10'(ASC_PERIODS) * (10'(halfLimit) + 10'h001) * 10'h002;

    always_ff @(posedge clk_sys) begin
        if (rst || state_q != ASC_CONV) begin
            convLen_q <= 10'h000;
            divTouched_q <= 1'b0;
        end else begin
            convLen_q <= convLen_q + 10'h001;
            divTouched_q <= divTouched_q || wrClk;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= ASC_IDLE;
            busy_q <= 1'b0;
            periodCnt_q <= 5'h00;
            result_q <= 12'h000;
        end else begin
            unique case (state_q)
                ASC_IDLE: begin
                    if (startRise) begin
                        state_q <= ASC_HELD;
                        busy_q <= 1'b1;
                    end
                end
                ASC_HELD: begin
                    if (startFall) begin
                        state_q <= ASC_CONV;
                        periodCnt_q <= 5'h00;
                    end
                end
                ASC_CONV: begin
                    if (startRise) begin
                        state_q <= ASC_HELD;
                    end else if (!powerDec) begin
                        state_q <= ASC_IDLE;
                        busy_q <= 1'b0;
                    end else if (convDone) begin
                        state_q <= ASC_IDLE;
                        busy_q <= 1'b0;
                        result_q <= convData;
                    end else if (convTick_q) begin
                        periodCnt_q <= periodCnt_q + 5'h01;
                    end
                end
            endcase
        end
    end

    // request flag: hardware set beats software clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irqFlag_q <= 1'b0;
        end else if (convDone && state_q == ASC_CONV && !startRise && powerDec) begin
            irqFlag_q <= 1'b1;
        end else if (wrClk && wb_sel_i[1] && !wb_dat_i[ASC_BIT_IRQ_FLAG]) begin
            irqFlag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pinEn_q <= ASC_NO_PINS;
            powerOn_q <= 1'b0;
            held_q <= 1'b1;
            irqOut_q <= 1'b0;
            chSel_q <= 3'h0;
            chValid_q <= 1'b0;
        end else begin
            // enabled pins override direction and pull-up at the port
            pinEn_q <= pinDec;
            powerOn_q <= powerDec;
            held_q <= (state_q != ASC_CONV);
            irqOut_q <= irqFlag_q && irqEn_q && globalEn_q;
            chSel_q <= chCode;
            chValid_q <= chOk && powerDec;
        end
    end

    assign wb_dat_o = rdData_q;
    assign wb_ack_o = ack_q;
    assign channelSelect = chSel_q;
    assign channelValid = chValid_q;
    assign analogPinEnable = pinEn_q;
    assign convPowerOn = powerOn_q;
    assign convReset = held_q;
    assign convClockEn = convTick_q;
    assign convInterrupt = irqOut_q;

    // ------------------------------------------------------------
    // checks: bus reads and register layout
    // ------------------------------------------------------------
    a_read_upper_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        (busReq && wb_adr_i != ASC_ADDR_CLKSRC) |=> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    a_result_low_nibble: assert property (
        @(posedge clk_sys) disable iff (rst)
        (busReq && !wb_we_i && wb_adr_i == ASC_ADDR_RES_LOW) |=> wb_dat_o[3:0] == 4'h0)
        else $error("low result register carries data in its low bits");

    a_busy_read: assert property (
        @(posedge clk_sys) disable iff (rst)
        (busReq && !wb_we_i && wb_adr_i == ASC_ADDR_CONTROL) |=>
        wb_dat_o[ASC_BIT_BUSY] == $past(busy_q))
        else $error("busy flag not at its control bit");

    a_busy_ro_write: assert property (
        @(posedge clk_sys) disable iff (rst)
        (wrCtrl && !startRise && state_q == ASC_IDLE) |=> !busy_q)
        else $error("write changed busy flag");

    // ------------------------------------------------------------
    // checks: sequencer, conversion clock and results
    // ------------------------------------------------------------
    a_busy_after_rise: assert property (
        @(posedge clk_sys) disable iff (rst)
        startRise |=> busy_q)
        else $error("busy not set by start rise");

    a_held_reset: assert property (
        @(posedge clk_sys) disable iff (rst)
        convReset == $past(state_q != ASC_CONV))
        else $error("converter reset does not follow the sequencer");

    a_launch_on_fall: assert property (
        @(posedge clk_sys) disable iff (rst)
        (state_q == ASC_HELD && startFall) |=> state_q == ASC_CONV)
        else $error("start fall did not launch");

    a_done_clears_busy: assert property (
        @(posedge clk_sys) disable iff (rst)
        (convDone && !startRise && powerDec) |=> !busy_q && irqFlag_q)
        else $error("completion did not clear busy or set flag");

    a_irq_gate: assert property (
        @(posedge clk_sys) disable iff (rst)
        convInterrupt == ($past(irqFlag_q) && $past(irqEn_q) && $past(globalEn_q)))
        else $error("interrupt does not follow flag and enables");

    a_power_gate: assert property (
        @(posedge clk_sys) disable iff (rst)
        convPowerOn == ($past(pinsUsed) && !$past(clkSrc_q[ASC_BIT_POWER_OFF])))
        else $error("converter power does not follow pins and power-off bit");

    a_pins_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        (pinCode == 3'h0) |=> analogPinEnable == ASC_NO_PINS)
        else $error("pins analog with zero code");

    a_pins_all: assert property (
        @(posedge clk_sys) disable iff (rst)
        (pinCode[2:1] == 2'b11) |=> &analogPinEnable)
        else $error("codes 6 and 7 must enable all pins");

    a_chan_valid: assert property (
        @(posedge clk_sys) disable iff (rst)
        channelValid == $past(chOk && powerDec))
        else $error("channel valid does not follow code and power");

    a_tick_single: assert property (
        @(posedge clk_sys) disable iff (rst)
        convTick_q |=> !convTick_q)
        else $error("conversion clock faster than half the system clock");

    a_conv_len_min: assert property (
        @(posedge clk_sys) disable iff (rst)
        ($rose(state_q == ASC_CONV) && divSel == ASC_DIV2 && !wrClk) |-> busy_q [*8])
        else $error("conversion ended too early");

    a_conv_length: assert property (
        @(posedge clk_sys) disable iff (rst)
        (convDone && !divTouched_q) |-> convLen_q == convLenExp)
        else $error("conversion length is not sixteen conversion clocks");

    a_result_latch: assert property (
        @(posedge clk_sys) disable iff (rst)
        (convDone && !startRise && powerDec) |=> result_q == $past(convData))
        else $error("result not taken at completion");

    a_result_hold: assert property (
        @(posedge clk_sys) disable iff (rst)
        (state_q != ASC_CONV) |=> $stable(result_q))
        else $error("result changed outside a completion");
endmodule // asc_control

// ---- tb/asc_sensor_model.sv ----
// analog sensor stand-in that feeds the converter core result
module asc_sensor_model import asc_pkg::*; (
    input wire logic clk_sys,
    input wire logic [2:0] channelSelect,
    input wire logic channelValid,
    input wire logic convPowerOn,
    output logic [ASC_DATA_W-1:0] convData
);
    timeunit 1ns;
    timeprecision 1ps;
    initial convData = 12'h000;
    // unrouted or unpowered input drifts each cycle instead of holding its last value
    always @(posedge clk_sys) begin
        if (convPowerOn && channelValid) begin
            convData <= 12'hA53 ^ {4{channelSelect}};
        end else begin
            convData <= ~convData + 12'h3B7;
        end
    end
endmodule // asc_sensor_model

// ---- tb/adc_sequencer_control_test.sv ----
// self-checking bench for the converter sequencer control block
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin errTotal++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module adc_sequencer_control_test import asc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [3:0] wbAdr = 4'h0;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR;
    logic [31:0] rdv;
    logic wbAck;
    logic [ASC_DATA_W-1:0] convData;
    logic [2:0] channelSelect;
    logic [ASC_CHANNELS-1:0] analogPinEnable;
    logic channelValid, convPowerOn, convReset, convClockEn, convInterrupt;
    int errTotal = 0;
    int nCompared = 0;
    int cycles = 0;
    int pulses = 0;
    int lastPulse = 0;
    int lastGap = 0;

    always #20 clk_sys = ~clk_sys;

    asc_control dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
        .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .convData(convData),
        .channelSelect(channelSelect), .channelValid(channelValid),
        .analogPinEnable(analogPinEnable), .convPowerOn(convPowerOn),
        .convReset(convReset), .convClockEn(convClockEn), .convInterrupt(convInterrupt));

    asc_sensor_model sensor (.clk_sys(clk_sys), .channelSelect(channelSelect),
        .channelValid(channelValid), .convPowerOn(convPowerOn), .convData(convData));

    // ----------------------------------------
    // monitor and hang guard
    // ----------------------------------------
    always @(posedge clk_sys) begin
        cycles++;
        if (convClockEn === 1'b1) begin
            pulses++;
            lastGap = cycles - lastPulse;
            lastPulse = cycles;
        end
        if (cycles > 8000) begin
            errTotal++;
            summarize();
        end
    end

    task automatic summarize();
        if (errTotal == 0 && nCompared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // bus access
    // ----------------------------------------
    task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                      input logic [31:0] wd);
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= sel;
        wbDatW <= wd;
        // only the bench timeout ends a wait for the answer
        do begin
            @(posedge clk_sys);
        end while (wbAck !== 1'b1);
        rdv = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    task automatic idle2();
        repeat (2) @(posedge clk_sys);
    endtask

    // one full start pulse, poll to completion, then results and request flag
    task automatic convert(input logic [2:0] ch, input logic [1:0] dv, input logic ie);
        logic [7:0] pinCh;
        logic [11:0] v;
        int n;
        int p0;
        pinCh = {2'b00, 3'h6, ch};
        v = 12'hA53 ^ {4{ch}};
        n = 0;
        wb(1'b1, ASC_ADDR_CLKSRC, 4'h3, {21'h0, ie, ie, 1'b0, 6'h00, dv});
        wb(1'b1, ASC_ADDR_CONTROL, 4'h1, {24'h0, pinCh | 8'h80});
        wb(1'b0, ASC_ADDR_CONTROL, 4'h1, 32'h0);
        `CHK(rdv, {24'h0, pinCh | 8'hC0})
        `CHK(convReset, 1'b1)
        p0 = pulses;
        wb(1'b1, ASC_ADDR_CONTROL, 4'h1, {24'h0, pinCh | 8'h40});
        do begin
            wb(1'b0, ASC_ADDR_CONTROL, 4'h1, 32'h0);
            n++;
        end while (rdv[ASC_BIT_BUSY] === 1'b1 && n < 400);
        `CHK(n > 1, 1'b1)
        `CHK(rdv, {24'h0, pinCh})
        `CHK(pulses - p0, 16)
        `CHK(lastGap, 2 << (2 * int'(dv)))
        `CHK(convInterrupt, ie)
        wb(1'b0, ASC_ADDR_CLKSRC, 4'h3, 32'h0);
        `CHK(rdv[ASC_BIT_IRQ_FLAG], 1'b1)
        wb(1'b0, ASC_ADDR_RES_HIGH, 4'h1, 32'h0);
        `CHK(rdv, {24'h0, v[11:4]})
        wb(1'b0, ASC_ADDR_RES_LOW, 4'h1, 32'h0);
        `CHK(rdv, {24'h0, v[3:0], 4'h0})
        wb(1'b1, ASC_ADDR_CLKSRC, 4'h3, {21'h0, 1'b1, 1'b1, 1'b0, 6'h00, dv});
        idle2();
        `CHK(convInterrupt, 1'b0)
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int i;
        logic [5:0] pe;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        wb(1'b0, ASC_ADDR_CONTROL, 4'h1, 32'h0);
        `CHK(rdv, {24'h0, ASC_CTRL_RESET})
        wb(1'b0, ASC_ADDR_CLKSRC, 4'h3, 32'h0);
        `CHK(rdv, {24'h0, ASC_CLKSRC_RESET})
        `CHK(convPowerOn, 1'b0)
        `CHK(analogPinEnable, ASC_NO_PINS)
        // unmapped place and a write without lane 0 must both leave control alone
        wb(1'b1, 4'h2, 4'h1, 32'hFF);
        wb(1'b1, ASC_ADDR_CONTROL, 4'h0, 32'hFF);
        wb(1'b0, ASC_ADDR_CONTROL, 4'h1, 32'h0);
        `CHK(rdv, 32'h0)
        wb(1'b0, 4'h2, 4'h1, 32'h0);
        `CHK(rdv, 32'h0)
        wb(1'b1, ASC_ADDR_CLKSRC, 4'h1, 32'h0);
        for (i = 0; i < 8; i++) begin
            pe = (i == 0) ? 6'h00 : (i >= 6) ? 6'h3F : 6'((1 << i) - 1);
            wb(1'b1, ASC_ADDR_CONTROL, 4'h1, {24'h0, 2'b00, 3'(i), 3'(i)});
            idle2();
            `CHK(analogPinEnable, pe)
            `CHK(convPowerOn, i != 0)
            `CHK(channelSelect, 3'(i))
            `CHK(channelValid, i != 0 && i <= 5)
        end
        wb(1'b1, ASC_ADDR_CLKSRC, 4'h1, 32'h80);
        idle2();
        `CHK(convPowerOn, 1'b0)
        // divide-by-two is too fast at this clock; one run only proves its decode
        for (i = 0; i < 6; i++) begin
            convert(3'(i), (i == 5) ? ASC_DIV2 : 2'(1 + i % 2), i != 5);
        end
        summarize();
    end
endmodule // adc_sequencer_control_test
